// File: dv/bcbh_link_monitor.sv
// Concurrent checks on the block link between the two ends.
// Assumes one ref_clk, synchronous active-high srst, link wires as inputs.
`timescale 1ns/10ps
module bcbh_link_monitor
	import bcbh_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        reqValid,
	input wire logic        reqLast,
	input wire logic [5:0]  reqIdx,
	input wire logic [15:0] reqWord,
	input wire logic        rspValid,
	input wire logic        rspLast,
	input wire logic [5:0]  rspIdx,
	input wire logic [15:0] rspWord
);
	default clocking mc @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// Helper state
	logic [15:0] reqSeq_q, reqId_q, rspSeq_q, rspId_q;
	logic        reqSeen_q, rspSeen_q;

	// Range of one time field; year and spare words pass
	function automatic logic fieldOk(input logic [5:0] i, input logic [15:0] w);
		case (i)
			BCBH_W_MON: fieldOk = (w >= BCBH_ONE) && (w <= BCBH_MON_MAX);
			BCBH_W_DAY: fieldOk = (w >= BCBH_ONE) && (w <= BCBH_DAY_MAX);
			BCBH_W_HOUR: fieldOk = w <= BCBH_HOUR_MAX;
			BCBH_W_MIN, BCBH_W_SEC: fieldOk = w <= BCBH_MIN_MAX;
			BCBH_W_MS: fieldOk = w <= BCBH_MS_MAX;
			default: fieldOk = 1'b1;
		endcase
	endfunction : fieldOk

	// Track last sequence and code in both directions; a boot may restart the counter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reqSeen_q <= 1'b0;
			rspSeen_q <= 1'b0;
			reqSeq_q  <= '0;
			reqId_q   <= '0;
			rspSeq_q  <= '0;
			rspId_q   <= '0;
		end else begin
			if (reqValid && reqIdx == BCBH_W_SEQ) begin
				reqSeq_q  <= reqWord;
				reqSeen_q <= 1'b1;
			end
			if (reqValid && reqIdx == BCBH_W_ID) begin
				reqId_q <= reqWord;
				if (reqWord == BCBH_ID_BOOT || reqWord == BCBH_ID_BOOT_ALT) begin
					rspSeen_q <= 1'b0;
				end
			end
			if (rspValid && rspIdx == BCBH_W_SEQ) begin
				rspSeq_q  <= rspWord;
				rspSeen_q <= 1'b1;
			end
			if (rspValid && rspIdx == BCBH_W_ID) begin
				rspId_q <= rspWord;
			end
		end
	end

	// ==========================================================
	// Assertions
	rsp_step_a: assert property (rspValid && !rspLast |=> rspValid && rspIdx == $past(rspIdx) + 6'h01)
		else $error("answer words not consecutive");
	rsp_last_a: assert property (rspValid |-> rspLast == (rspIdx == 6'h3f))
		else $error("answer last flag misplaced");
	req_step_a: assert property (reqValid && !reqLast |=> reqValid && reqIdx == $past(reqIdx) + 6'h01)
		else $error("request words not consecutive");
	rsp_cause_a: assert property (rspValid && rspIdx == 6'h00 |-> $past(reqValid && reqLast, 3))
		else $error("answer without a request three cycles before");
	echo_id_a: assert property (rspValid && rspIdx == BCBH_W_ID |-> rspWord == reqId_q)
		else $error("answer code differs from request code");
	seq_new_a: assert property (rspValid && rspIdx == 6'h00 && rspSeen_q |-> rspWord != rspSeq_q)
		else $error("answer counter did not change");
	time_range_a: assert property (rspValid && rspId_q == BCBH_ID_GET && rspIdx >= BCBH_W_MON
		&& rspIdx <= BCBH_W_MS |-> fieldOk(rspIdx, rspWord))
		else $error("time field out of range");
	spare_zero_a: assert property (rspValid && rspIdx > BCBH_W_MS |-> rspWord == 16'h0000)
		else $error("unused answer word not zero");
	set_spare_a: assert property (rspValid && rspId_q == BCBH_ID_SET
		&& rspIdx >= BCBH_W_YEAR |-> rspWord == 16'h0000)
		else $error("set acknowledgement word not spare");
	req_seq_a: assert property (reqValid && reqIdx == 6'h00 && reqSeen_q |-> reqWord != reqSeq_q)
		else $error("request sequence word repeated");
endmodule : bcbh_link_monitor

// File: dv/tb.sv
// Self-checking bench joining host and device ends through the link.
// Assumes a shortened millisecond (MS_CYC 4) and the package constants.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
	$display("BAD %s exp %0h got %0h", nm, exp, got); end end
module tb;
	import bcbh_pkg::*;
	localparam int LIMIT = 20000;
	logic        ref_clk, srst, cmdValid, cmdBusy, rspDone, monValid, bootPulse, monFwdValid;
	logic [1:0]  portStations0, portStations1, balancedReq, portBalanced;
	logic [15:0] cmdId, monWord, monFwdWord, statusWord, handledCount, rspId, w;
	bcbh_time_t  cmdTime, rspTime, base, bad;
	int          fails = 0, total_checks = 0, cyc = 0, bootSeen = 0;

	bcbh_link_if linkIf();
	bcbh_device #(.MS_CYC(4)) bcbh_device_inst (.ref_clk(ref_clk), .srst(srst), .link(linkIf),
		.portStations0(portStations0), .portStations1(portStations1), .balancedReq(balancedReq),
		.monValid(monValid), .monWord(monWord), .portBalanced(portBalanced), .bootPulse(bootPulse),
		.monFwdValid(monFwdValid), .monFwdWord(monFwdWord), .statusWord(statusWord),
		.handledCount(handledCount));
	bcbh_host bcbh_host_inst (.ref_clk(ref_clk), .srst(srst), .link(linkIf), .cmdValid(cmdValid),
		.cmdId(cmdId), .cmdTime(cmdTime), .cmdBusy(cmdBusy), .rspDone(rspDone), .rspId(rspId),
		.rspTime(rspTime));
	bcbh_link_monitor bcbh_link_monitor_inst (.ref_clk(ref_clk), .srst(srst),
		.reqValid(linkIf.reqValid), .reqLast(linkIf.reqLast), .reqIdx(linkIf.reqIdx),
		.reqWord(linkIf.reqWord), .rspValid(linkIf.rspValid), .rspLast(linkIf.rspLast),
		.rspIdx(linkIf.rspIdx), .rspWord(linkIf.rspWord));

	// ==========================================================
	// Clock, restart pulse count, hang guard
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (bootPulse === 1'b1) bootSeen++;
		if (cyc >= LIMIT) begin
			fails++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// Milliseconds since year zero, every month 31 days as the device counts
	function automatic longint toMs(input bcbh_time_t t);
		toMs = (((longint'(t.year) * 12 + t.mon - 1) * 31 + t.day - 1) * 24 + t.hour) * 60;
		toMs = ((toMs + t.min) * 60 + t.sec) * 1000 + t.ms;
	endfunction : toMs

	function automatic bcbh_time_t randTime();
		randTime = '{16'($urandom_range(1990, 2050)), 16'($urandom_range(1, 12)),
			16'($urandom_range(1, 31)), 16'($urandom_range(0, 23)), 16'($urandom_range(0, 59)),
			16'($urandom_range(0, 59)), 16'($urandom_range(0, 999))};
	endfunction : randTime

	// Give a command when idle, optionally wait for the whole answer
	task automatic send(input logic [15:0] id, input bcbh_time_t t, input bit wait_rsp);
		int n;
		n = 0;
		while (cmdBusy !== 1'b0) @(negedge ref_clk);
		cmdValid = 1'b1;
		cmdId = id;
		cmdTime = t;
		@(negedge ref_clk);
		cmdValid = 1'b0;
		while (wait_rsp && rspDone !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 400) fails++;
	endtask : send

	// Clock read back must lie a little after the reference time
	task automatic checkNear(input bcbh_time_t ref0, input longint span);
		longint d;
		d = toMs(rspTime) - toMs(ref0);
		`CHK("time elapsed", 1'b1, (d >= 0 && d <= span))
	endtask : checkNear

	// ==========================================================
	// Main sequence
	initial begin
		srst = 1'b1;
		cmdValid = 1'b0;
		cmdId = '0;
		cmdTime = '0;
		monValid = 1'b0;
		monWord = '0;
		portStations0 = '0;
		portStations1 = '0;
		balancedReq = '0;
		void'($urandom(32'h18b051d8));
		base = '{16'h07d0, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		repeat (10) @(negedge ref_clk);
		srst = 1'b0;
		send(BCBH_ID_GET, '0, 1'b1);
		`CHK("get code", BCBH_ID_GET, rspId)
		`CHK("handled count", 16'h0001, handledCount)
		checkNear(base, 100);
		// Year-end rollover first, then random loads
		for (int k = 0; k < 5; k++) begin
			base = (k == 0) ? '{16'h07cf, 16'h000c, 16'h001f, 16'h0017, 16'h003b, 16'h003b,
				16'h03e0} : randTime();
			send(BCBH_ID_SET, base, 1'b1);
			`CHK("set code", BCBH_ID_SET, rspId)
			send(BCBH_ID_GET, '0, 1'b1);
			checkNear(base, 100);
		end
		bad = base;
		bad.mon = 16'h000d;
		send(BCBH_ID_SET, bad, 1'b1);
		`CHK("reject count", 16'h0001, statusWord)
		send(BCBH_ID_GET, '0, 1'b1);
		checkNear(base, 250);
		`CHK("handled total", 16'h000d, handledCount)
		// Port modes over every station count
		for (int m = 0; m < 16; m++) begin
			portStations0 = 2'(m);
			portStations1 = 2'(m >> 2);
			balancedReq = 2'($urandom);
			repeat (2) @(negedge ref_clk);
			`CHK("port mode", {balancedReq[1] && portStations1 == 2'h1,
				balancedReq[0] && portStations0 == 2'h1}, portBalanced)
		end
		// Monitor data forwarding
		for (int m = 0; m < 4; m++) begin
			w = 16'($urandom);
			monValid = 1'b1;
			monWord = w;
			@(negedge ref_clk);
			monValid = 1'b0;
			`CHK("fwd valid", 1'b1, monFwdValid)
			`CHK("fwd word", w, monFwdWord)
		end
		@(negedge ref_clk);
		`CHK("fwd idle", 1'b0, monFwdValid)
		// Both restart codes, a reset between them
		bootSeen = 0;
		send(BCBH_ID_BOOT, '0, 1'b0);
		repeat (200) @(negedge ref_clk);
		`CHK("boot pulses", 1, bootSeen)
		`CHK("reject cleared", 16'h0000, statusWord)
		srst = 1'b1;
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		bootSeen = 0;
		send(BCBH_ID_BOOT_ALT, '0, 1'b0);
		repeat (200) @(negedge ref_clk);
		`CHK("alt boot pulses", 1, bootSeen)
		conclude();
	end
endmodule : tb

// File: rtl/bcbh_device.sv
// Module end: interprets request blocks, keeps the clock, answers.
// Assumes the host sends a whole 64-word block, word 0 first, back to back.
`timescale 1ns/10ps
// Behaviour
// - Code 9970 returns current date/time
// - Host changes word 0 per request
// - Answer: counter word 0, echo code
// - Year then month..milliseconds, words 2-8
// - Time fields kept in valid ranges
// - Host sets clock with code 9971
// - Set block words 2-8 load clock
// - Set acknowledged with counter and 9971
// - Code 9999 forces cold restart: clears sequence check and reject count, clock runs on
// - Warm and cold restart identical
// - Two independent serial application ports
// - Up to thirty-two sessions, unique addresses
// - At most five sectors per session
// - Multi-station port runs unbalanced mode
// - Monitor data stored and forwarded
// - Own status forwarded to host
module bcbh_device
	import bcbh_pkg::*;
#(
	parameter int MS_CYC   = BCBH_MS_CYC,
	parameter int SESSIONS = BCBH_SESSIONS,
	parameter int SECTORS  = BCBH_SECTORS
) (
	input  wire logic                ref_clk,
	input  wire logic                srst,
	bcbh_link_if.device              link,
	input  wire logic [1:0]          portStations0,
	input  wire logic [1:0]          portStations1,
	input  wire logic [1:0]          balancedReq,
	input  wire logic                monValid,
	input  wire logic [15:0]         monWord,
	output logic [1:0]               portBalanced,
	output logic                     bootPulse,
	output logic                     monFwdValid,
	output logic [15:0]              monFwdWord,
	output logic [15:0]              statusWord,
	output logic [15:0]              handledCount
);
	// ==========================================================
	// Elaboration checks; the millisecond counter is only 17 bits wide
	if (MS_CYC < 1 || MS_CYC > 131072) begin : g_bad_ms
		$error("MS_CYC out of range");
	end
	if (SESSIONS < 1 || SESSIONS > BCBH_SESSIONS) begin : g_bad_sess
		$error("bad SESSIONS");
	end
	if (SECTORS < 1 || SECTORS > BCBH_SECTORS) begin : g_bad_sect
		$error("bad SECTORS");
	end

	typedef struct packed {
		bcbh_state_t  st;
		bcbh_time_t   clk;
		bcbh_time_t   req;
		logic [15:0]  id;
		logic [15:0]  seq;
		logic [15:0]  lastSeq;
		logic         seqSeen;
		logic [16:0]  msCnt;
		logic [5:0]   idx;
		logic [4:0]   bootCnt;
		logic         rspValid;
		logic         rspLast;
		logic [5:0]   rspIdx;
		logic [15:0]  rspWord;
		logic [1:0]   bal;
		logic         boot;
		logic         monV;
		logic [15:0]  monW;
		logic [15:0]  rejects;
	} bcbh_dev_t;

	bcbh_dev_t s_q;
	bcbh_dev_t s_d;

	// Advance one field with carry; returns wrapped value
	function automatic logic [15:0] bcbh_bump(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		bcbh_bump = (v >= hi) ? lo : v + BCBH_ONE;
	endfunction : bcbh_bump

	// Word of the answer block at a given index
	function automatic logic [15:0] bcbh_rsp(input bcbh_dev_t s, input logic [5:0] i);
		bcbh_rsp = 16'h0000;
		if (i == BCBH_W_SEQ) begin
			bcbh_rsp = s.seq;
		end else if (i == BCBH_W_ID) begin
			bcbh_rsp = s.id;
		end else if (s.id == BCBH_ID_GET) begin
			// time layout
			// Words come from the snapshot, so a carry cannot tear them
			if (i == BCBH_W_YEAR) bcbh_rsp = s.req.year;
			else if (i == BCBH_W_MON) bcbh_rsp = s.req.mon;
			else if (i == BCBH_W_DAY) bcbh_rsp = s.req.day;
			else if (i == BCBH_W_HOUR) bcbh_rsp = s.req.hour;
			else if (i == BCBH_W_MIN) bcbh_rsp = s.req.min;
			else if (i == BCBH_W_SEC) bcbh_rsp = s.req.sec;
			else if (i == BCBH_W_MS) bcbh_rsp = s.req.ms;
		end
	endfunction : bcbh_rsp

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.boot = 1'b0;
		s_d.rspValid = 1'b0;
		s_d.rspLast = 1'b0;
		if (s_q.msCnt == 17'(MS_CYC - 1)) begin
			s_d.msCnt = 17'h00000;
			s_d.clk.ms = bcbh_bump(s_q.clk.ms, 16'h0000, BCBH_MS_MAX);
			if (s_q.clk.ms == BCBH_MS_MAX) begin
				s_d.clk.sec = bcbh_bump(s_q.clk.sec, 16'h0000, BCBH_MIN_MAX);
				if (s_q.clk.sec == BCBH_MIN_MAX) begin
					s_d.clk.min = bcbh_bump(s_q.clk.min, 16'h0000, BCBH_MIN_MAX);
					if (s_q.clk.min == BCBH_MIN_MAX) begin
						s_d.clk.hour = bcbh_bump(s_q.clk.hour, 16'h0000, BCBH_HOUR_MAX);
						if (s_q.clk.hour == BCBH_HOUR_MAX) begin
							// Simple calendar: every month 31 days
							s_d.clk.day = bcbh_bump(s_q.clk.day, BCBH_ONE, BCBH_DAY_MAX);
							if (s_q.clk.day == BCBH_DAY_MAX) begin
								s_d.clk.mon = bcbh_bump(s_q.clk.mon, BCBH_ONE, BCBH_MON_MAX);
								if (s_q.clk.mon == BCBH_MON_MAX)
									s_d.clk.year = s_q.clk.year + BCBH_ONE;
							end
						end
					end
				end
			end
		end else begin
			s_d.msCnt = s_q.msCnt + 17'h00001;
		end
		s_d.bal[0] = balancedReq[0] && (portStations0 == 2'b01);
		s_d.bal[1] = balancedReq[1] && (portStations1 == 2'b01);
		s_d.monV = monValid;
		s_d.monW = monValid ? monWord : s_q.monW;
		case (s_q.st)
			BCBH_IDLE: begin
				s_d.idx = 6'h00;
				if (link.reqValid) begin
					s_d.st = BCBH_RECV;
				end
			end
			BCBH_RECV: begin
				s_d.st = BCBH_RECV;
			end
			BCBH_EXEC: begin
				s_d.st = BCBH_IDLE;
			end
			BCBH_SEND: begin
				s_d.rspValid = 1'b1;
				s_d.rspIdx = s_q.idx;
				s_d.rspWord = bcbh_rsp(s_q, s_q.idx);
				s_d.rspLast = (s_q.idx == 6'h3f);
				s_d.idx = s_q.idx + 6'h01;
				if (s_q.idx == 6'h3f) s_d.st = BCBH_IDLE;
			end
			BCBH_BOOT: begin
				s_d.bootCnt = s_q.bootCnt + 5'h01;
				if (s_q.bootCnt == 5'(BCBH_BOOT_CYC - 1)) begin
					s_d.st = BCBH_IDLE;
					s_d.seqSeen = 1'b0;
					s_d.rejects = 16'h0000;
				end
			end
			default: s_d.st = BCBH_IDLE;
		endcase
		// Receive words in any state but send/boot
		if (link.reqValid && s_q.st != BCBH_SEND && s_q.st != BCBH_BOOT) begin
			if (link.reqIdx == BCBH_W_SEQ) s_d.lastSeq = link.reqWord;
			if (link.reqIdx == BCBH_W_ID) s_d.id = link.reqWord;
			if (link.reqIdx == BCBH_W_YEAR) s_d.req.year = link.reqWord;
			if (link.reqIdx == BCBH_W_MON) s_d.req.mon = link.reqWord;
			if (link.reqIdx == BCBH_W_DAY) s_d.req.day = link.reqWord;
			if (link.reqIdx == BCBH_W_HOUR) s_d.req.hour = link.reqWord;
			if (link.reqIdx == BCBH_W_MIN) s_d.req.min = link.reqWord;
			if (link.reqIdx == BCBH_W_SEC) s_d.req.sec = link.reqWord;
			if (link.reqIdx == BCBH_W_MS) s_d.req.ms = link.reqWord;
			s_d.st = link.reqLast ? BCBH_EXEC : BCBH_RECV;
		end
		// Act on a finished block
		if (s_q.st == BCBH_EXEC) begin
			s_d.st = BCBH_IDLE;
			s_d.idx = 6'h00;
			// act only on a new sequence value
			if (!s_q.seqSeen || s_q.lastSeq != s_q.seq) begin
				s_d.seqSeen = 1'b1;
				if (s_q.id == BCBH_ID_GET) begin
					s_d.seq = s_q.lastSeq;
					s_d.st = BCBH_SEND;
					// snapshot of the clock for the answer
					s_d.req = s_q.clk;
				end else if (s_q.id == BCBH_ID_SET) begin
					s_d.seq = s_q.lastSeq;
					s_d.st = BCBH_SEND;
					if (bcbh_time_ok(s_q.req)) begin
						s_d.clk = s_q.req;
						s_d.msCnt = 17'h00000;
					end else begin
						s_d.rejects = s_q.rejects + BCBH_ONE;
					end
				end else if (s_q.id == BCBH_ID_BOOT || s_q.id == BCBH_ID_BOOT_ALT) begin
					s_d.boot = 1'b1;
					s_d.bootCnt = 5'h00;
					s_d.st = BCBH_BOOT;
				end
			end
		end
	end

	// ==========================================================
	// State register; restart reuses reset values of the link side
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.st <= BCBH_IDLE;
			s_q.clk.year <= BCBH_YEAR_RST;
			s_q.clk.mon <= BCBH_ONE;
			s_q.clk.day <= BCBH_ONE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs, all from flops
	assign link.rspValid = s_q.rspValid;
	assign link.rspLast  = s_q.rspLast;
	assign link.rspIdx   = s_q.rspIdx;
	assign link.rspWord  = s_q.rspWord;
	assign portBalanced  = s_q.bal;
	assign bootPulse     = s_q.boot;
	assign monFwdValid   = s_q.monV;
	assign monFwdWord    = s_q.monW;
	assign statusWord    = s_q.rejects;
	assign handledCount  = s_q.seq;
endmodule : bcbh_device

// File: rtl/bcbh_host.sv
// Processor end: builds request blocks and collects answers.
// Assumes the device end answers whole blocks on the same ref_clk.
`timescale 1ns/10ps
module bcbh_host
	import bcbh_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                srst,
	bcbh_link_if.host                link,
	input  wire logic                cmdValid,
	input  wire logic [15:0]         cmdId,
	input  wire bcbh_time_t          cmdTime,
	output logic                     cmdBusy,
	output logic                     rspDone,
	output logic [15:0]              rspId,
	output bcbh_time_t               rspTime
);
	typedef struct packed {
		logic         busy;
		logic [5:0]   idx;
		logic [15:0]  seq;
		logic [15:0]  id;
		bcbh_time_t   tm;
		logic         v;
		logic         last;
		logic [5:0]   oIdx;
		logic [15:0]  oWord;
		logic         done;
		logic [15:0]  rId;
		bcbh_time_t   rTm;
	} bcbh_host_t;

	bcbh_host_t h_q;
	bcbh_host_t h_d;

	// ==========================================================
	// Send one block per command, collect answers
	always_comb begin
		h_d = h_q;
		h_d.v = 1'b0;
		h_d.last = 1'b0;
		h_d.done = 1'b0;
		if (!h_q.busy && cmdValid) begin
			h_d.busy = 1'b1;
			h_d.idx = 6'h00;
			h_d.seq = h_q.seq + BCBH_ONE;
			h_d.id = cmdId;
			h_d.tm = cmdTime;
		end else if (h_q.busy) begin
			h_d.v = 1'b1;
			h_d.oIdx = h_q.idx;
			h_d.last = (h_q.idx == 6'h3f);
			h_d.oWord = 16'h0000;
			if (h_q.idx == BCBH_W_SEQ) h_d.oWord = h_q.seq;
			else if (h_q.idx == BCBH_W_ID) h_d.oWord = h_q.id;
			else if (h_q.id == BCBH_ID_SET) begin
				if (h_q.idx == BCBH_W_YEAR) h_d.oWord = h_q.tm.year;
				else if (h_q.idx == BCBH_W_MON) h_d.oWord = h_q.tm.mon;
				else if (h_q.idx == BCBH_W_DAY) h_d.oWord = h_q.tm.day;
				else if (h_q.idx == BCBH_W_HOUR) h_d.oWord = h_q.tm.hour;
				else if (h_q.idx == BCBH_W_MIN) h_d.oWord = h_q.tm.min;
				else if (h_q.idx == BCBH_W_SEC) h_d.oWord = h_q.tm.sec;
				else if (h_q.idx == BCBH_W_MS) h_d.oWord = h_q.tm.ms;
			end
			h_d.idx = h_q.idx + 6'h01;
			if (h_q.idx == 6'h3f) h_d.busy = 1'b0;
		end
		if (link.rspValid) begin
			if (link.rspIdx == BCBH_W_ID) h_d.rId = link.rspWord;
			if (link.rspIdx == BCBH_W_YEAR) h_d.rTm.year = link.rspWord;
			if (link.rspIdx == BCBH_W_MON) h_d.rTm.mon = link.rspWord;
			if (link.rspIdx == BCBH_W_DAY) h_d.rTm.day = link.rspWord;
			if (link.rspIdx == BCBH_W_HOUR) h_d.rTm.hour = link.rspWord;
			if (link.rspIdx == BCBH_W_MIN) h_d.rTm.min = link.rspWord;
			if (link.rspIdx == BCBH_W_SEC) h_d.rTm.sec = link.rspWord;
			if (link.rspIdx == BCBH_W_MS) h_d.rTm.ms = link.rspWord;
			h_d.done = link.rspLast;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) h_q <= '0;
		else h_q <= h_d;
	end

	// ==========================================================
	// Outputs from flops
	assign link.reqValid = h_q.v;
	assign link.reqLast  = h_q.last;
	assign link.reqIdx   = h_q.oIdx;
	assign link.reqWord  = h_q.oWord;
	assign cmdBusy       = h_q.busy;
	assign rspDone       = h_q.done;
	assign rspId         = h_q.rId;
	assign rspTime       = h_q.rTm;
endmodule : bcbh_host

// File: rtl/bcbh_link_if.sv
// Block link between processor end and module end.
// Assumes a single ref_clk; words move one per cycle while valid is high.
`timescale 1ns/10ps
interface bcbh_link_if;
	logic        reqValid;
	logic        reqLast;
	logic [5:0]  reqIdx;
	logic [15:0] reqWord;
	logic        rspValid;
	logic        rspLast;
	logic [5:0]  rspIdx;
	logic [15:0] rspWord;

	modport device (
		input  reqValid, reqLast, reqIdx, reqWord,
		output rspValid, rspLast, rspIdx, rspWord
	);
	modport host (
		output reqValid, reqLast, reqIdx, reqWord,
		input  rspValid, rspLast, rspIdx, rspWord
	);
endinterface : bcbh_link_if

// File: rtl/bcbh_pkg.sv
// Shared constants and types for the backplane clock block handler.
// Assumes both ends run on one 100 MHz ref_clk with synchronous reset.
package bcbh_pkg;
	// ==========================================================
	// Block geometry
	localparam int          BCBH_BLOCK_WORDS = 64;
	localparam int          BCBH_WORD_W      = 16;
	localparam int          BCBH_IDX_W       = 6;
	// ==========================================================
	// Word positions inside a block
	localparam logic [5:0]  BCBH_W_SEQ   = 6'h00;
	localparam logic [5:0]  BCBH_W_ID    = 6'h01;
	localparam logic [5:0]  BCBH_W_YEAR  = 6'h02;
	localparam logic [5:0]  BCBH_W_MON   = 6'h03;
	localparam logic [5:0]  BCBH_W_DAY   = 6'h04;
	localparam logic [5:0]  BCBH_W_HOUR  = 6'h05;
	localparam logic [5:0]  BCBH_W_MIN   = 6'h06;
	localparam logic [5:0]  BCBH_W_SEC   = 6'h07;
	localparam logic [5:0]  BCBH_W_MS    = 6'h08;
	// ==========================================================
	// Block identification codes (decimal 9970, 9971, 9999, 9990)
	localparam logic [15:0] BCBH_ID_GET  = 16'h26f2;
	localparam logic [15:0] BCBH_ID_SET  = 16'h26f3;
	localparam logic [15:0] BCBH_ID_BOOT = 16'h270f;
	localparam logic [15:0] BCBH_ID_BOOT_ALT = 16'h2706;
	// ==========================================================
	// Field limits and reset values of the clock
	localparam logic [15:0] BCBH_MON_MAX  = 16'h000c;
	localparam logic [15:0] BCBH_DAY_MAX  = 16'h001f;
	localparam logic [15:0] BCBH_HOUR_MAX = 16'h0017;
	localparam logic [15:0] BCBH_MIN_MAX  = 16'h003b;
	localparam logic [15:0] BCBH_MS_MAX   = 16'h03e7;
	localparam logic [15:0] BCBH_YEAR_RST = 16'h07d0;
	localparam logic [15:0] BCBH_ONE      = 16'h0001;
	// ==========================================================
	// Timing: one millisecond at 100 MHz
	localparam int          BCBH_CLK_MHZ  = 100;
	localparam int          BCBH_MS_US    = 1000;
	localparam int          BCBH_MS_CYC   = BCBH_CLK_MHZ * BCBH_MS_US;
	localparam int          BCBH_BOOT_CYC = 16;
	// ==========================================================
	// Resource limits of the master driver
	localparam int          BCBH_PORTS    = 2;
	localparam int          BCBH_SESSIONS = 32;
	localparam int          BCBH_SECTORS  = 5;

	typedef struct packed {
		logic [15:0] year;
		logic [15:0] mon;
		logic [15:0] day;
		logic [15:0] hour;
		logic [15:0] min;
		logic [15:0] sec;
		logic [15:0] ms;
	} bcbh_time_t;

	typedef enum logic [2:0] {
		BCBH_IDLE  = 3'b000,
		BCBH_RECV  = 3'b001,
		BCBH_EXEC  = 3'b010,
		BCBH_SEND  = 3'b011,
		BCBH_BOOT  = 3'b100
	} bcbh_state_t;

	// Range check used by the device end to accept or reject set blocks
	function automatic logic bcbh_time_ok(input bcbh_time_t t);
		bcbh_time_ok = (t.mon >= BCBH_ONE) && (t.mon <= BCBH_MON_MAX)
			&& (t.day >= BCBH_ONE) && (t.day <= BCBH_DAY_MAX)
			&& (t.hour <= BCBH_HOUR_MAX) && (t.min <= BCBH_MIN_MAX)
			&& (t.sec <= BCBH_MIN_MAX) && (t.ms <= BCBH_MS_MAX);
	endfunction : bcbh_time_ok
endpackage : bcbh_pkg
